// ===== aplu_host.sv
// Purpose: host register master facing the limit unit
// Assumes: AXI4-Lite, one write and one read at a time
// Notes:   taken lines show inverted data, never the old value
`timescale 1ns/10ps
module aplu_host (
  input  wire logic        i_ref_clk,
  output logic [7:0]       o_awaddr,
  output logic             o_awvalid,
  input  wire logic        i_awready,
  output logic [31:0]      o_wdata,
  output logic             o_wvalid,
  input  wire logic        i_wready,
  input  wire logic [1:0]  i_bresp,
  input  wire logic        i_bvalid,
  output logic             o_bready,
  output logic [7:0]       o_araddr,
  output logic             o_arvalid,
  input  wire logic        i_arready,
  input  wire logic [31:0] i_rdata,
  input  wire logic        i_rvalid,
  output logic             o_rready
);
  // ****************
  // bus cycles
  // ****************
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_araddr, o_wdata} = 48'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 1'b0;
    @(posedge i_ref_clk);
    {o_awaddr, o_wdata} <= {a, d};
    {o_awvalid, o_wvalid, o_bready} <= 3'h7;
    while (!done) begin
      @(posedge i_ref_clk);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata  <= ~d;
      end
      if (o_bready && i_bvalid) begin
        r = i_bresp;
        o_bready <= 1'b0;
        done = 1'b1;
      end
    end
    // derived outputs settle before the caller looks
    repeat (3) @(posedge i_ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bit done;
    done = 1'b0;
    @(posedge i_ref_clk);
    o_araddr <= a;
    {o_arvalid, o_rready} <= 2'h3;
    while (!done) begin
      @(posedge i_ref_clk);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr  <= ~a;
      end
      if (o_rready && i_rvalid) begin
        o_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  task automatic target_short(input logic [15:0] s, output logic [1:0] r);
    wr(aplu_pkg::OFS_DEST_LOW, {16'h0, s}, r);
    wr(aplu_pkg::OFS_DEST_HIGH, 32'h0, r);
  endtask : target_short
endmodule : aplu_host

// ===== aplu_pkg.sv
// Purpose: constants and carriers for the addressing and payload limit unit
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes:   offsets are byte addresses of aligned words
package aplu_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_OWN_SHORT  = 8'h00;
  localparam logic [7:0] OFS_DEST_LOW   = 8'h04;
  localparam logic [7:0] OFS_DEST_HIGH  = 8'h08;
  localparam logic [7:0] OFS_PAN        = 8'h0c;
  localparam logic [7:0] OFS_CTRL       = 8'h10;
  localparam logic [7:0] OFS_SERIAL_LO  = 8'h14;
  localparam logic [7:0] OFS_SERIAL_HI  = 8'h18;
  localparam logic [7:0] OFS_KEY0       = 8'h20;
  localparam logic [7:0] OFS_TX_REQ     = 8'h30;
  localparam logic [7:0] OFS_STATUS     = 8'h34;
  localparam logic [7:0] OFS_RX_REQ     = 8'h38;
  localparam logic [7:0] OFS_RX_RESULT  = 8'h3c;
  localparam logic [7:0] OFS_ADDR_INFO  = 8'h40;
  localparam logic [7:0] OFS_SPLIT      = 8'h44;

  // ctrl fields
  localparam int CTRL_CIPHER_BIT = 0;
  localparam int CTRL_COMPAT_BIT = 1;
  localparam int CTRL_MODE_LSB   = 2;
  localparam int CTRL_API_BIT    = 4;
  localparam int CTRL_ASSOC_BIT  = 5;

  // ****************************************
  // reset values and special addresses
  // ****************************************
  localparam logic [15:0] RST_OWN_SHORT = 16'h0000;
  localparam logic [15:0] RST_PAN       = 16'h3332;
  localparam logic [15:0] ADDR_BCAST    = 16'hffff;
  localparam logic [15:0] ADDR_NOSHORT  = 16'hfffe;

  // ****************************************
  // payload figures
  // ****************************************
  localparam logic [7:0] PL_BASE       = 8'd116;
  localparam logic [7:0] PL_COMPAT     = 8'd100;
  localparam logic [7:0] PL_COMPAT_ENC = 8'd95;
  localparam logic [7:0] PL_HDR_PLAIN  = 8'd2;
  localparam logic [7:0] PL_HDR_ENC    = 8'd4;
  localparam logic [7:0] PL_LONG_ADDR  = 8'd6;
  localparam logic [7:0] PL_SEC_OVH    = 8'd5;

  // ****************************************
  // frame codes
  // ****************************************
  localparam logic [7:0] FT_TX64      = 8'h00;
  localparam logic [7:0] FT_TX16      = 8'h01;
  localparam logic [7:0] FT_RX64      = 8'h80;
  localparam logic [7:0] FT_RX16      = 8'h81;
  localparam logic [7:0] FT_TX_STATUS = 8'h89;
  localparam logic [7:0] ST_OK        = 8'h00;
  localparam logic [7:0] ST_TOO_LARGE = 8'd74;
  localparam logic [2:0] SEC_LVL_NONE = 3'd0;
  localparam logic [2:0] SEC_LVL_ENC  = 3'd4;

  typedef struct packed {
    logic        awdone;
    logic        wdone;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [1:0]  bresp;
  } aplu_bus_t;

  typedef struct packed {
    logic [15:0]  own_short_address;
    logic [31:0]  dest_addr_low;
    logic [31:0]  dest_addr_high;
    logic [15:0]  network_pan_number;
    logic [127:0] cipher_key;
    logic         cipher_enable;
    logic         legacy_compat_flags;
    logic [1:0]   mac_header_mode;
    logic         api_mode;
    logic [7:0]   max_payload;
    logic [7:0]   max_payload_query;
    logic [7:0]   tx_frame_type;
    logic [7:0]   tx_status;
    logic         tx_refused;
    logic [7:0]   rx_frame_type;
    logic         rx_deliver;
    logic [15:0]  split_left;
    logic [7:0]   split_chunk;
  } aplu_cfg_t;

endpackage : aplu_pkg

// ===== aplu_top.sv
// Purpose: addressing selection and payload limit for a low-rate radio
// Assumes: host writes settings over AXI4-Lite; serial number strapped
// Notes:   limit is combinational from settings, registered once
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
module aplu_top #(
  parameter logic [63:0] SERIAL_NUMBER = 64'h0000_0000_0000_0001 // arbitrary
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [63:0]      o_src_long_addr,
  output logic             o_src_is_long,
  output logic             o_dest_bcast,
  output logic             o_pan_bcast,
  output logic [2:0]       o_sec_level,
  output logic [7:0]       o_max_payload
);

  typedef struct packed {
    aplu_pkg::aplu_bus_t bus;
    aplu_pkg::aplu_cfg_t cfg;
    logic [63:0]         src_long;
    logic                src_is_long;
    logic                dest_bcast;
    logic                pan_bcast;
    logic [2:0]          sec_level;
  } aplu_state_t;

  aplu_state_t st_reg;
  aplu_state_t st_next;

  logic        hdr_on;
  logic        src_long_c;
  logic [7:0]  lim_long_dst;
  logic [7:0]  lim_short_dst;
  logic [7:0]  req_len;
  logic        req_short;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic [7:0]  waddr;
  logic [31:0] wval;

  // ****************************************
  // payload limit
  // ****************************************
  // combinational recompute
  always_comb begin
    hdr_on = (st_reg.cfg.mac_header_mode == 2'd0) || (st_reg.cfg.mac_header_mode == 2'd3);
    src_long_c = (st_reg.cfg.own_short_address == aplu_pkg::ADDR_BCAST)
              || (st_reg.cfg.own_short_address == aplu_pkg::ADDR_NOSHORT)
              || st_reg.cfg.cipher_enable;
    lim_short_dst = aplu_pkg::PL_BASE;
    if (hdr_on) begin
      lim_short_dst = lim_short_dst - (st_reg.cfg.cipher_enable ? aplu_pkg::PL_HDR_ENC
                                                                 : aplu_pkg::PL_HDR_PLAIN);
    end
    if (src_long_c) begin
      lim_short_dst = lim_short_dst - aplu_pkg::PL_LONG_ADDR;
    end
    if (st_reg.cfg.cipher_enable) begin
      lim_short_dst = lim_short_dst - aplu_pkg::PL_SEC_OVH;
    end
    lim_long_dst = lim_short_dst - aplu_pkg::PL_LONG_ADDR;
    if (st_reg.cfg.legacy_compat_flags) begin
      lim_short_dst = st_reg.cfg.cipher_enable ? aplu_pkg::PL_COMPAT_ENC : aplu_pkg::PL_COMPAT;
      lim_long_dst  = lim_short_dst;
    end
  end

  // ****************************************
  // bus and state update
  // ****************************************
  always_comb begin
    wr_fire = st_reg.bus.awdone && st_reg.bus.wdone && !st_reg.bus.bvalid;
    rd_fire = s_axi_arvalid && !st_reg.bus.rvalid;
    waddr   = st_reg.bus.awaddr;
    wval    = st_reg.bus.wdata;
    wmask   = 32'h0000_0000;
    req_len = wval[7:0];
    req_short = wval[8];
    unique case (s_axi_araddr)
      aplu_pkg::OFS_OWN_SHORT: rd_val = {16'h0000, st_reg.cfg.own_short_address};
      aplu_pkg::OFS_DEST_LOW:  rd_val = st_reg.cfg.dest_addr_low;
      aplu_pkg::OFS_DEST_HIGH: rd_val = st_reg.cfg.dest_addr_high;
      aplu_pkg::OFS_PAN:       rd_val = {16'h0000, st_reg.cfg.network_pan_number};
      aplu_pkg::OFS_CTRL:      rd_val = {27'h0000000, st_reg.cfg.api_mode,
                                         st_reg.cfg.mac_header_mode,
                                         st_reg.cfg.legacy_compat_flags,
                                         st_reg.cfg.cipher_enable};
      aplu_pkg::OFS_SERIAL_LO: rd_val = SERIAL_NUMBER[31:0];
      aplu_pkg::OFS_SERIAL_HI: rd_val = SERIAL_NUMBER[63:32];
      aplu_pkg::OFS_TX_REQ:    rd_val = {24'h000000, st_reg.cfg.tx_frame_type};
      aplu_pkg::OFS_STATUS:    rd_val = {8'h00, st_reg.cfg.tx_refused, 7'h00,
                                         st_reg.cfg.tx_status, st_reg.cfg.max_payload_query};
      aplu_pkg::OFS_RX_RESULT: rd_val = {23'h000000, st_reg.cfg.rx_deliver,
                                         st_reg.cfg.rx_frame_type};
      aplu_pkg::OFS_ADDR_INFO: rd_val = {28'h0000000, st_reg.sec_level[2], st_reg.pan_bcast,
                                         st_reg.dest_bcast, st_reg.src_is_long};
      aplu_pkg::OFS_SPLIT:     rd_val = {8'h00, st_reg.cfg.split_chunk, st_reg.cfg.split_left};
      // key is write-only; other addresses read zero
      default:                 rd_val = 32'h0000_0000;
    endcase
    for (int b = 0; b < 4; b++) begin
      if (s_axi_wstrb[b] || st_reg.bus.wdone) begin
        wmask[b*8 +: 8] = 8'hff;
      end
    end

    st_next = st_reg;
    // write channel capture, either order
    if (s_axi_awvalid && !st_reg.bus.awdone) begin
      st_next.bus.awdone = 1'b1;
      st_next.bus.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.bus.wdone) begin
      st_next.bus.wdone = 1'b1;
      st_next.bus.wdata = s_axi_wdata & wmask;
    end
    if (wr_fire) begin
      st_next.bus.bvalid = 1'b1;
      st_next.bus.bresp  = 2'b00;
      unique case (waddr)
        aplu_pkg::OFS_OWN_SHORT: st_next.cfg.own_short_address = wval[15:0];
        // host loads low and high words
        aplu_pkg::OFS_DEST_LOW:  st_next.cfg.dest_addr_low = wval;
        aplu_pkg::OFS_DEST_HIGH: st_next.cfg.dest_addr_high = wval;
        aplu_pkg::OFS_PAN:       st_next.cfg.network_pan_number = wval[15:0];
        aplu_pkg::OFS_CTRL: begin
          st_next.cfg.cipher_enable       = wval[aplu_pkg::CTRL_CIPHER_BIT];
          st_next.cfg.legacy_compat_flags = wval[aplu_pkg::CTRL_COMPAT_BIT];
          st_next.cfg.mac_header_mode     = wval[aplu_pkg::CTRL_MODE_LSB +: 2];
          st_next.cfg.api_mode            = wval[aplu_pkg::CTRL_API_BIT];
          if (wval[aplu_pkg::CTRL_ASSOC_BIT]) begin
            st_next.cfg.own_short_address = aplu_pkg::ADDR_NOSHORT;
          end
        end
        aplu_pkg::OFS_TX_REQ: begin
          st_next.cfg.tx_frame_type = req_short ? aplu_pkg::FT_TX16 : aplu_pkg::FT_TX64;
          if (st_reg.cfg.api_mode
              && req_len > (req_short ? lim_short_dst : lim_long_dst)) begin
            st_next.cfg.tx_refused = 1'b1;
            st_next.cfg.tx_status  = aplu_pkg::ST_TOO_LARGE;
          end else begin
            st_next.cfg.tx_refused = 1'b0;
            st_next.cfg.tx_status  = aplu_pkg::ST_OK;
          end
        end
        aplu_pkg::OFS_RX_REQ: begin
          st_next.cfg.rx_deliver = (wval[0] == st_reg.cfg.cipher_enable);
          if (wval[0] && !wval[2]) begin
            st_next.cfg.rx_frame_type = aplu_pkg::FT_RX64;
          end else begin
            st_next.cfg.rx_frame_type = wval[1] ? aplu_pkg::FT_RX64 : aplu_pkg::FT_RX16;
          end
        end
        aplu_pkg::OFS_SPLIT: begin
          st_next.cfg.split_left = wval[15:0];
        end
        default: begin
          // sixteen key bytes in four words
          if (waddr[7:4] == aplu_pkg::OFS_KEY0[7:4]) begin
            st_next.cfg.cipher_key[waddr[3:2]*32 +: 32] = wval;
          end else begin
            st_next.bus.bresp = 2'b10;
          end
        end
      endcase
    end
    if (st_reg.bus.bvalid && s_axi_bready) begin
      st_next.bus.bvalid = 1'b0;
      st_next.bus.awdone = 1'b0;
      st_next.bus.wdone  = 1'b0;
    end
    if (rd_fire) begin
      st_next.bus.rvalid = 1'b1;
      st_next.bus.rdata  = rd_val;
      st_next.bus.rresp  = 2'b00;
    end else if (st_reg.bus.rvalid && s_axi_rready) begin
      st_next.bus.rvalid = 1'b0;
    end

    // transparent chunk sizing, reading the split register consumes one chunk
    if (rd_fire && s_axi_araddr == aplu_pkg::OFS_SPLIT && !st_reg.cfg.api_mode) begin
      st_next.cfg.split_left = (st_reg.cfg.split_left > {8'h00, st_reg.cfg.max_payload})
                             ? st_reg.cfg.split_left - {8'h00, st_reg.cfg.max_payload}
                             : 16'h0000;
    end
    st_next.cfg.split_chunk = (st_next.cfg.split_left > {8'h00, st_reg.cfg.max_payload})
                            ? st_reg.cfg.max_payload : st_next.cfg.split_left[7:0];

    st_next.cfg.max_payload = lim_long_dst;
    st_next.cfg.max_payload_query = lim_long_dst;
    st_next.src_is_long = src_long_c;
    st_next.src_long = src_long_c ? SERIAL_NUMBER
                                  : {48'h0000_0000_0000, st_reg.cfg.own_short_address};
    st_next.dest_bcast = (st_reg.cfg.dest_addr_high == 32'h0000_0000)
                      && (st_reg.cfg.dest_addr_low == {16'h0000, aplu_pkg::ADDR_BCAST});
    st_next.pan_bcast = (st_reg.cfg.network_pan_number == aplu_pkg::ADDR_BCAST);
    st_next.sec_level = st_reg.cfg.cipher_enable ? aplu_pkg::SEC_LVL_ENC : aplu_pkg::SEC_LVL_NONE;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
      st_reg.cfg.network_pan_number <= aplu_pkg::RST_PAN;
      st_reg.cfg.own_short_address  <= aplu_pkg::RST_OWN_SHORT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready   = !st_reg.bus.awdone;
  assign s_axi_wready    = !st_reg.bus.wdone;
  assign s_axi_bvalid    = st_reg.bus.bvalid;
  assign s_axi_bresp     = st_reg.bus.bresp;
  assign s_axi_arready   = !st_reg.bus.rvalid;
  assign s_axi_rvalid    = st_reg.bus.rvalid;
  assign s_axi_rdata     = st_reg.bus.rdata;
  assign s_axi_rresp     = st_reg.bus.rresp;
  assign o_src_long_addr = st_reg.src_long;
  assign o_src_is_long   = st_reg.src_is_long;
  assign o_dest_bcast    = st_reg.dest_bcast;
  assign o_pan_bcast     = st_reg.pan_bcast;
  assign o_sec_level     = st_reg.sec_level;
  assign o_max_payload   = st_reg.cfg.max_payload;

  // ****************************************
  // checks
  // ****************************************
  property p_compat;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      st_reg.cfg.legacy_compat_flags |=> (o_max_payload ==
        ($past(st_reg.cfg.cipher_enable) ? 8'd95 : 8'd100));
  endproperty
  a_compat: assert property (p_compat) else $error("compat limit wrong");

  property p_base;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!st_reg.cfg.legacy_compat_flags && !st_reg.cfg.cipher_enable && !hdr_on && !src_long_c)
      |=> (o_max_payload == 8'd110);
  endproperty
  a_base: assert property (p_base) else $error("base limit wrong");

  property p_enc;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (!st_reg.cfg.legacy_compat_flags && st_reg.cfg.cipher_enable)
      |=> (o_max_payload == ($past(hdr_on) ? 8'd95 : 8'd99));
  endproperty
  a_enc: assert property (p_enc) else $error("encrypted limit wrong");

  property p_src;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (st_reg.cfg.own_short_address == 16'hfffe) |=> o_src_is_long
        && (o_src_long_addr == SERIAL_NUMBER);
  endproperty
  a_src: assert property (p_src) else $error("long source missed");

  property p_bcast;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (st_reg.cfg.network_pan_number == 16'hffff) |=> o_pan_bcast;
  endproperty
  a_bcast: assert property (p_bcast) else $error("network broadcast missed");

  property p_sec;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 (o_sec_level == ($past(st_reg.cfg.cipher_enable) ? 3'd4 : 3'd0));
  endproperty
  a_sec: assert property (p_sec) else $error("security level wrong");

  property p_refuse;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (wr_fire && waddr == aplu_pkg::OFS_TX_REQ && st_reg.cfg.api_mode && !req_short
       && req_len > lim_long_dst) |=> st_reg.cfg.tx_refused && st_reg.cfg.tx_status == 8'd74;
  endproperty
  a_refuse: assert property (p_refuse) else $error("oversize not refused");

  property p_query;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      $past(i_rst_n) |-> (st_reg.cfg.max_payload_query == $past(lim_long_dst));
  endproperty
  a_query: assert property (p_query) else $error("query limit wrong");

  property p_key;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (wr_fire && waddr[7:4] == aplu_pkg::OFS_KEY0[7:4])
      |=> (st_reg.cfg.cipher_key[$past(waddr[3:2])*32 +: 32] == $past(wval));
  endproperty
  a_key: assert property (p_key) else $error("key word not held");

  property p_dest;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (st_reg.cfg.dest_addr_high == 32'h0000_0000
       && st_reg.cfg.dest_addr_low == 32'h0000_ffff) |=> o_dest_bcast;
  endproperty
  a_dest: assert property (p_dest) else $error("destination broadcast missed");

  property p_chunk;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 (st_reg.cfg.split_chunk <= $past(st_reg.cfg.max_payload));
  endproperty
  a_chunk: assert property (p_chunk) else $error("chunk above limit");

  property p_deliver;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (wr_fire && waddr == aplu_pkg::OFS_RX_REQ && (wval[0] != st_reg.cfg.cipher_enable))
      |=> !st_reg.cfg.rx_deliver;
  endproperty
  a_deliver: assert property (p_deliver) else $error("mismatched cipher delivered");

  property p_rxlong;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      (wr_fire && waddr == aplu_pkg::OFS_RX_REQ && wval[0] && !wval[2])
      |=> (st_reg.cfg.rx_frame_type == 8'h80);
  endproperty
  a_rxlong: assert property (p_rxlong) else $error("headerless cipher not long");

endmodule : aplu_top

// ===== aplu_top_test.sv
// Purpose: self-checking bench for the addressing and payload limit unit
// Assumes: register master in aplu_host, reads checked from a note queue
// Notes:   write strobes full words except one masked write
`timescale 1ns/10ps
module aplu_top_test;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } aplu_note_t;
  localparam logic [63:0] SERIAL = 64'h0123_4567_89ab_cdef; // arbitrary
  logic        i_ref_clk = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, o_max_payload;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [63:0] o_src_long_addr;
  logic [2:0]  o_sec_level;
  logic        o_src_is_long, o_dest_bcast, o_pan_bcast;
  logic [15:0] seed = 16'hdb64;
  aplu_note_t  notes[$];
  int          bad_count, n_compared, cycles;

  aplu_top #(.SERIAL_NUMBER(SERIAL)) u_dut (
    .i_ref_clk, .i_rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .o_src_long_addr, .o_src_is_long, .o_dest_bcast,
    .o_pan_bcast, .o_sec_level, .o_max_payload
  );
  aplu_host u_host (
    .i_ref_clk, .o_awaddr(s_axi_awaddr), .o_awvalid(s_axi_awvalid),
    .i_awready(s_axi_awready), .o_wdata(s_axi_wdata), .o_wvalid(s_axi_wvalid),
    .i_wready(s_axi_wready), .i_bresp(s_axi_bresp), .i_bvalid(s_axi_bvalid),
    .o_bready(s_axi_bready), .o_araddr(s_axi_araddr), .o_arvalid(s_axi_arvalid),
    .i_arready(s_axi_arready), .i_rdata(s_axi_rdata), .i_rvalid(s_axi_rvalid),
    .o_rready(s_axi_rready)
  );

  // ****************
  // helpers
  // ****************
  always #25 i_ref_clk = ~i_ref_clk;

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [7:0] lim(input logic enc, cmp, lng, hdr);
    logic [7:0] l;
    if (cmp) return enc ? aplu_pkg::PL_COMPAT_ENC : aplu_pkg::PL_COMPAT;
    l = aplu_pkg::PL_BASE - aplu_pkg::PL_LONG_ADDR;
    if (hdr) l = l - (enc ? aplu_pkg::PL_HDR_ENC : aplu_pkg::PL_HDR_PLAIN);
    if (lng || enc) l = l - aplu_pkg::PL_LONG_ADDR;
    if (enc) l = l - aplu_pkg::PL_SEC_OVH;
    return l;
  endfunction : lim

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rd(input aplu_note_t n);
    chk({32'h0, s_axi_rdata & n.m}, {32'h0, n.v & n.m});
  endtask : chk_rd

  task automatic rx(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{v: v, m: m});
    u_host.rd(a);
  endtask : rx

  task automatic wx(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_host.wr(a, d, r);
  endtask : wx

  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge i_ref_clk) begin
    cycles++;
    if (s_axi_rvalid && s_axi_rready) begin
      if (notes.size() > 0) chk_rd(notes.pop_front());
      else chk({32'h0, s_axi_rdata}, 64'h1);
      chk({62'h0, s_axi_rresp}, 64'h0);
    end
    // hang guard, far above the expected run
    if (cycles == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    logic [1:0]  br;
    logic [15:0] own;
    logic [7:0]  lm, x;
    logic        hdr;
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rx(aplu_pkg::OFS_OWN_SHORT, {16'h0, aplu_pkg::RST_OWN_SHORT}, 32'hffff);
    rx(aplu_pkg::OFS_PAN, {16'h0, aplu_pkg::RST_PAN}, 32'hffff);
    for (int c = 0; c < 32; c++) begin
      seed = lfsr_next(seed);
      own = c[4] ? (c[0] ? 16'hffff : 16'hfffe) : {1'b0, seed[14:0]};
      hdr = (c[3:2] == 2'd0) || (c[3:2] == 2'd3);
      lm = lim(c[0], c[1], c[4], hdr);
      wx(aplu_pkg::OFS_OWN_SHORT, {16'h0, own});
      wx(aplu_pkg::OFS_CTRL, {27'h0, 1'b1, c[3:0]});
      chk({56'h0, o_max_payload}, {56'h0, lm});
      chk({61'h0, o_sec_level}, {61'h0, c[0] ? 3'd4 : 3'd0});
      chk({63'h0, o_src_is_long}, {63'h0, c[4] | c[0]});
      chk(o_src_long_addr, (c[4] | c[0]) ? SERIAL : {48'h0, own});
      rx(aplu_pkg::OFS_STATUS, {24'h0, lm}, 32'hff);
      for (int t = 0; t < 4; t++) begin
        x = (t[1] && !c[1]) ? lm + aplu_pkg::PL_LONG_ADDR : lm;
        wx(aplu_pkg::OFS_TX_REQ, {23'h0, t[1], x + {7'h0, t[0]}});
        rx(aplu_pkg::OFS_STATUS, {8'h0, t[0], 7'h0,
           t[0] ? aplu_pkg::ST_TOO_LARGE : aplu_pkg::ST_OK, 8'h0}, 32'h80ff00);
        rx(aplu_pkg::OFS_TX_REQ, {24'h0, t[1] ? aplu_pkg::FT_TX16 : aplu_pkg::FT_TX64},
           32'hff);
      end
      for (int r = 0; r < 4; r++) begin
        wx(aplu_pkg::OFS_RX_REQ, {29'h0, hdr, r[1:0]});
        rx(aplu_pkg::OFS_RX_RESULT, {23'h0, r[0] == c[0],
           ((c[0] && !hdr) || r[1]) ? aplu_pkg::FT_RX64 : aplu_pkg::FT_RX16},
           (r[0] == c[0]) ? 32'h1ff : 32'h100);
      end
    end
    for (int k = 0; k < 3; k++) begin
      seed = lfsr_next(seed);
      u_host.target_short((k == 0) ? seed : 16'hffff, br);
      if (k == 2) wx(aplu_pkg::OFS_DEST_HIGH, 32'h1);
      chk({63'h0, o_dest_bcast}, {63'h0, k == 1 || (k == 0 && seed == 16'hffff)});
      wx(aplu_pkg::OFS_PAN, {16'h0, (k == 1) ? 16'hffff : seed});
      chk({63'h0, o_pan_bcast}, {63'h0, k == 1 || seed == 16'hffff});
    end
    wx(aplu_pkg::OFS_OWN_SHORT, 32'h1234);
    wx(aplu_pkg::OFS_CTRL, 32'h20);
    rx(aplu_pkg::OFS_OWN_SHORT, {16'h0, aplu_pkg::ADDR_NOSHORT}, 32'hffff);
    chk(o_src_long_addr, SERIAL);
    rx(aplu_pkg::OFS_SERIAL_LO, SERIAL[31:0], 32'hffffffff);
    rx(aplu_pkg::OFS_SERIAL_HI, SERIAL[63:32], 32'hffffffff);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr_next(seed);
      wx(aplu_pkg::OFS_KEY0 + 8'(4 * k), {seed, ~seed});
      rx(aplu_pkg::OFS_KEY0 + 8'(4 * k), 32'h0, 32'hffffffff);
    end
    u_host.wr(8'hfc, 32'h5a5a_5a5a, br);
    chk({62'h0, br}, 64'h2);
    rx(8'hfc, 32'h0, 32'hffffffff);
    // low two byte lanes only
    s_axi_wstrb <= 4'h3;
    wx(aplu_pkg::OFS_DEST_LOW, 32'h5a5a_a5a5);
    s_axi_wstrb <= 4'hf;
    rx(aplu_pkg::OFS_DEST_LOW, 32'h0000_a5a5, 32'hffffffff);
    wx(aplu_pkg::OFS_CTRL, 32'h0);
    wx(aplu_pkg::OFS_SPLIT, 32'd250);
    lm = lim(1'b0, 1'b0, 1'b1, 1'b1);
    rx(aplu_pkg::OFS_SPLIT, {8'h0, lm, 16'd250}, 32'hffffff);
    rx(aplu_pkg::OFS_SPLIT, {8'h0, lm, 16'd250 - {8'h0, lm}}, 32'hffffff);
    rx(aplu_pkg::OFS_SPLIT, {8'h0, 8'd250 - lm - lm, 8'h0, 8'd250 - lm - lm},
       32'hffffff);
    repeat (2) @(posedge i_ref_clk);
    report_and_stop();
  end
endmodule : aplu_top_test
